/* File: src/hsp_defs.svh */
// constants for the serial port pin control block
// assumes it is included by bare name wherever a constant is needed
`ifndef HSP_DEFS_SVH
`define HSP_DEFS_SVH

`define HSP_SYNC_STAGES   2
`define HSP_PIN_COUNT     4
`define HSP_PIN_STRAP     0
`define HSP_PIN_SCLK      1
`define HSP_PIN_SDIO      2
`define HSP_PIN_ADDR_ONE  3
`define HSP_PIN_ADDR_ZERO 4
`define HSP_STRAP_I2C     1'b1
`define HSP_LATCH_DELAY   2'h3
`define HSP_CFG_WIDTH     8
`define HSP_CFG_RESET     8'h00
`define HSP_CFG_4WIRE_BIT 0
`define HSP_STATUS_WIDTH  8
`define HSP_IRQ_IDLE      1'b1

`endif

/* File: src/hsp_pin_ctrl.sv */
// pin front end of the configuration serial port
// assumes the serial engine and status logic sit on clock_in beside it,
// and that reset_n_in is the device reset pin, already clean of glitches
`timescale 1ns/1ps
`include "hsp_defs.svh"
`default_nettype none
module hsp_pin_ctrl
	import hsp_pkg::*;
(
	input  wire logic                         clock_in,
	input  wire logic                         reset_n_in,
	input  wire logic                         iface_sel_in,
	input  wire logic                         serial_clk_in,
	input  wire logic                         serial_in_line_in,
	output logic                              serial_in_line_out,
	output logic                              serial_in_line_oe_out,
	input  wire logic                         addr_bit_one_in,
	output logic                              serial_out_line_out,
	output logic                              serial_out_line_oe_out,
	input  wire logic                         addr_bit_zero_in,
	input  wire logic                         tx_bit_in,
	input  wire logic                         tx_en_in,
	input  wire logic                         cfg_wr_in,
	input  wire logic [`HSP_CFG_WIDTH-1:0]    cfg_wdata_in,
	input  wire logic [`HSP_STATUS_WIDTH-1:0] status_in,
	input  wire logic                         irq_ack_in,
	output logic                              mode_i2c_out,
	output logic                              mode_spi_out,
	output logic                              frame_active_out,
	output logic                              sclk_rise_out,
	output logic                              sclk_fall_out,
	output logic                              rx_bit_out,
	output logic [1:0]                        i2c_addr_out,
	output logic [`HSP_CFG_WIDTH-1:0]         cfg_out,
	output logic                              status_change_irq_low_out,
	output logic                              clk_outputs_en_out
);
	////////////////////////////////////////////////////////////////////////
	// declarations
	hsp_pin_if pin_if ();                        // synchronised pins
	hsp_mode_t              mode_r;               // latched port mode
	logic [1:0]             lat_cnt_r;            // cycles since reset release
	logic                   latched_r;            // strap has been taken
	logic                   sclk_prev_r;          // serial clock last cycle
	logic [`HSP_CFG_WIDTH-1:0]    cfg_r;          // configuration register
	logic [`HSP_STATUS_WIDTH-1:0] status_prev_r;  // status last cycle
	logic                   irq_pend_r;           // status change pending
	logic                   irq_pend_nxt;         // next pending value
	logic                   status_change;        // any status bit moved
	logic                   spi_sel;              // spi mode and chip selected
	logic                   spi4;                 // 4-wire spi configured
	logic                   sclk_rise;            // serial clock rising edge
	logic                   sclk_fall;            // serial clock falling edge

	// pin vector in synchroniser order, chip select last
	hsp_pin_sync #(
		.WIDTH(`HSP_PIN_COUNT + 1)
	) hsp_pin_sync_inst (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.pins_in    ({addr_bit_zero_in, addr_bit_one_in, serial_in_line_in,
		              serial_clk_in, iface_sel_in}),
		.pin_if     (pin_if)
	);

	////////////////////////////////////////////////////////////////////////
	// decode helpers
	function automatic logic is_spi4(input hsp_mode_t m, input logic [`HSP_CFG_WIDTH-1:0] c);
		is_spi4 = (m == HSP_MODE_SPI) && c[`HSP_CFG_4WIRE_BIT];
	endfunction

	// chip select low frames an spi transaction, high leaves lines ignored
	assign spi_sel       = (mode_r == HSP_MODE_SPI) && !pin_if.addr_zero_s;
	assign spi4          = is_spi4(mode_r, cfg_r);
	// edges come from the host clock pin only
	assign sclk_rise     = pin_if.sclk_s && !sclk_prev_r;
	assign sclk_fall     = !pin_if.sclk_s && sclk_prev_r;
	assign status_change = |(status_in ^ status_prev_r);
	// a change in the clearing cycle keeps the flag set
	assign irq_pend_nxt  = status_change || (irq_pend_r && !irq_ack_in);

	////////////////////////////////////////////////////////////////////////
	// strap latch: wait for the synchroniser to fill, then take it once
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lat_cnt_r <= 2'h0;
			latched_r <= 1'b0;
			mode_r    <= HSP_MODE_WAIT;
		end else if (!latched_r) begin
			lat_cnt_r <= lat_cnt_r + 2'h1;
			if (lat_cnt_r == `HSP_LATCH_DELAY - 2'h1) begin
				latched_r <= 1'b1;
				// high strap gives i2c, low gives spi
				mode_r    <= (pin_if.strap_s == `HSP_STRAP_I2C) ? HSP_MODE_I2C
				                                                : HSP_MODE_SPI;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration register, back to defaults on every reset
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg_r <= `HSP_CFG_RESET;
		end else if (cfg_wr_in) begin
			cfg_r <= cfg_wdata_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial clock edge detection and receive path
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sclk_prev_r      <= 1'b0;
			sclk_rise_out    <= 1'b0;
			sclk_fall_out    <= 1'b0;
			rx_bit_out       <= 1'b0;
			frame_active_out <= 1'b0;
		end else begin
			sclk_prev_r <= pin_if.sclk_s;
			// i2c sees every edge, spi only while selected
			if ((mode_r == HSP_MODE_I2C) || spi_sel) begin
				sclk_rise_out <= sclk_rise;
				sclk_fall_out <= sclk_fall;
			end else begin
				sclk_rise_out <= 1'b0;
				sclk_fall_out <= 1'b0;
			end
			// data pin is the input in every mode
			rx_bit_out       <= pin_if.sdio_s;
			frame_active_out <= spi_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers per mode
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			serial_in_line_out     <= 1'b0;
			serial_in_line_oe_out  <= 1'b0;
			serial_out_line_out    <= 1'b0;
			serial_out_line_oe_out <= 1'b0;
		end else if (mode_r == HSP_MODE_I2C) begin
			// open drain data: pull low only, address-one stays an input
			serial_in_line_out     <= 1'b0;
			serial_in_line_oe_out  <= tx_en_in && !tx_bit_in;
			serial_out_line_out    <= 1'b0;
			serial_out_line_oe_out <= 1'b0;
		end else if (spi_sel && spi4) begin
			// 4-wire: read data on address-one pin, data pin input only
			serial_in_line_out     <= 1'b0;
			serial_in_line_oe_out  <= 1'b0;
			serial_out_line_out    <= tx_bit_in;
			serial_out_line_oe_out <= tx_en_in;
		end else if (spi_sel) begin
			// 3-wire: read data back on the shared data pin
			serial_in_line_out     <= tx_bit_in;
			serial_in_line_oe_out  <= tx_en_in;
			serial_out_line_out    <= 1'b0;
			serial_out_line_oe_out <= 1'b0;
		end else begin
			// deselected or waiting: drive nothing
			serial_in_line_out     <= 1'b0;
			serial_in_line_oe_out  <= 1'b0;
			serial_out_line_out    <= 1'b0;
			serial_out_line_oe_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// i2c hardware address bits and mode flags
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			i2c_addr_out <= 2'h0;
			mode_i2c_out <= 1'b0;
			mode_spi_out <= 1'b0;
		end else begin
			if (mode_r == HSP_MODE_I2C) begin
				i2c_addr_out <= {pin_if.addr_one_s, pin_if.addr_zero_s};
			end
			mode_i2c_out <= (mode_r == HSP_MODE_I2C);
			mode_spi_out <= (mode_r == HSP_MODE_SPI);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status change interrupt, low while a change is pending
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status_prev_r             <= '0;
			irq_pend_r                <= 1'b0;
			status_change_irq_low_out <= `HSP_IRQ_IDLE;
		end else begin
			status_prev_r             <= status_in;
			irq_pend_r                <= irq_pend_nxt;
			status_change_irq_low_out <= !irq_pend_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock outputs, off through reset and until the mode is known
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_outputs_en_out <= 1'b0;
			cfg_out            <= `HSP_CFG_RESET;
		end else begin
			clk_outputs_en_out <= latched_r;
			cfg_out            <= cfg_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	sequence latch_moment;
		!latched_r && (lat_cnt_r == `HSP_LATCH_DELAY - 2'h1);
	endsequence

	strap_mode_sel_a: assert property (latch_moment |=> ##1
		(mode_i2c_out == $past(pin_if.strap_s, 2)))
		else $error("mode does not follow strap");
	mode_held_a: assert property (latched_r |=> $stable(mode_r) && latched_r)
		else $error("mode changed after latch");
	spi3_bidir_a: assert property ((spi_sel && !spi4 && tx_en_in) |=>
		serial_in_line_oe_out && (serial_in_line_out == $past(tx_bit_in)) &&
		!serial_out_line_oe_out)
		else $error("3-wire read data not on data pin");
	spi4_input_a: assert property (
		((mode_r == HSP_MODE_SPI) && cfg_r[`HSP_CFG_4WIRE_BIT]) |=> !serial_in_line_oe_out)
		else $error("data pin driven in 4-wire mode");
	spi4_out_pin_a: assert property ((spi_sel && spi4 && tx_en_in) |=>
		serial_out_line_oe_out && (serial_out_line_out == $past(tx_bit_in)))
		else $error("4-wire read data not on address-one pin");
	i2c_addr_one_a: assert property ((mode_r == HSP_MODE_I2C) |=>
		(i2c_addr_out[1] == $past(pin_if.addr_one_s)) && !serial_out_line_oe_out)
		else $error("address-one bit wrong");
	i2c_addr_zero_a: assert property ((mode_r == HSP_MODE_I2C) |=>
		i2c_addr_out[0] == $past(pin_if.addr_zero_s))
		else $error("address-zero bit wrong");
	cs_ignore_a: assert property (((mode_r == HSP_MODE_SPI) && pin_if.addr_zero_s) |=>
		!sclk_rise_out && !sclk_fall_out && !serial_in_line_oe_out && !serial_out_line_oe_out)
		else $error("lines used while deselected");
	// an edge pulse lasts exactly one cycle
	sequence rise_pulse;
		sclk_rise_out ##1 !sclk_rise_out;
	endsequence
	sclk_edge_a: assert property ((spi_sel && sclk_rise) |=> rise_pulse)
		else $error("serial clock edge missed");
	irq_on_change_a: assert property (status_change |=> !status_change_irq_low_out)
		else $error("interrupt not raised on change");
	clk_off_wait_a: assert property (!latched_r |=> !clk_outputs_en_out)
		else $error("clock outputs enabled early");
endmodule
`default_nettype wire

/* File: src/hsp_pin_if.sv */
// carrier for synchronised pin levels between the synchroniser and the top
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface hsp_pin_if;
	logic strap_s;   // interface select strap, synchronised
	logic sclk_s;    // host serial clock, synchronised
	logic sdio_s;    // shared data pin, synchronised
	logic addr_one_s;   // address-one pin, synchronised
	logic addr_zero_s;  // address-zero / chip select, synchronised

	modport sync_side (output strap_s, output sclk_s, output sdio_s,
		output addr_one_s, output addr_zero_s);
	modport core_side (input strap_s, input sclk_s, input sdio_s,
		input addr_one_s, input addr_zero_s);
endinterface
`default_nettype wire

/* File: src/hsp_pin_sync.sv */
// two-flop synchronisers for every pin that enters from outside
// assumes raw pins are asynchronous to clock_in
`timescale 1ns/1ps
`include "hsp_defs.svh"
`default_nettype none
module hsp_pin_sync #(
	parameter int WIDTH = `HSP_PIN_COUNT + 1
) (
	input  wire logic             clock_in,
	input  wire logic             reset_n_in,
	input  wire logic [WIDTH-1:0] pins_in,
	hsp_pin_if.sync_side          pin_if
);
	logic [WIDTH-1:0] meta_r;   // first stage, read only by the second stage
	logic [WIDTH-1:0] sync_r;   // second stage, safe to use

	////////////////////////////////////////////////////////////////////////
	// one synchroniser per pin
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_sync
			// both stages reset to zero
			always_ff @(posedge clock_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					meta_r[g] <= 1'b0;
					sync_r[g] <= 1'b0;
				end else begin
					meta_r[g] <= pins_in[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// hand the settled levels to the top
	assign pin_if.strap_s = sync_r[`HSP_PIN_STRAP];
	assign pin_if.sclk_s  = sync_r[`HSP_PIN_SCLK];
	assign pin_if.sdio_s  = sync_r[`HSP_PIN_SDIO];
	assign pin_if.addr_one_s  = sync_r[`HSP_PIN_ADDR_ONE];
	assign pin_if.addr_zero_s = sync_r[`HSP_PIN_ADDR_ZERO];
endmodule
`default_nettype wire

/* File: src/hsp_pkg.sv */
// types shared by the serial port pin control block
// assumes the constants header is available on the include path
package hsp_pkg;
	// port mode, one-hot, wait is the state before the strap is latched
	typedef enum logic [2:0] {
		HSP_MODE_WAIT = 3'b001,
		HSP_MODE_I2C  = 3'b010,
		HSP_MODE_SPI  = 3'b100
	} hsp_mode_t;
endpackage

/* File: tb/host_serial_port_pin_control_test.sv */
// self-checking bench for the serial port pin front end
// assumes the design sources and the host model are compiled before it
`timescale 1ns/1ps
`include "hsp_defs.svh"
`default_nettype none
module host_serial_port_pin_control_test
	import hsp_pkg::*;
;
	logic       clock_in = 1'b0;   // 25 MHz system clock
	logic       reset_n  = 1'b0;   // device reset, active low
	logic       iface_sel = 1'b0;  // interface strap
	logic       tx_bit = 1'b0;     // engine read data
	logic       tx_en = 1'b0;      // engine sending
	logic       cfg_wr = 1'b0;     // config write strobe
	logic [7:0] cfg_wdata = 8'h00; // config value
	logic [7:0] status = 8'h00;    // monitored status
	logic       irq_ack = 1'b0;    // interrupt acknowledge
	wire logic  sclk, addr_zero_pin, host_addr_one, host_d, host_oe;
	wire logic  sdio_o, sdio_oe, addr_one_o, addr_one_oe;
	wire logic  m_i2c, m_spi, frame, rise, fall, rx_bit;
	wire logic  irq_low, clk_en, sdio, addr_one_pin;
	wire logic [1:0] i2c_addr;
	wire logic [7:0] cfg;
	int         err_total = 0;     // mismatches
	int         comparisons = 0;   // checks made
	int         rise_cnt = 0;      // host clock rise pulses seen
	int         fall_cnt = 0;      // host clock fall pulses seen
	int         r0, f0;            // counter snapshots
	// data pin: anyone pulling low wins, pull-up otherwise
	assign sdio = ((sdio_oe & ~sdio_o) | (host_oe & ~host_d)) ? 1'b0 : 1'b1;
	assign addr_one_pin = addr_one_oe ? addr_one_o : host_addr_one;
	always #20 clock_in = ~clock_in;
	// count edge pulses
	always @(posedge clock_in) begin
		if (rise === 1'b1) rise_cnt <= rise_cnt + 1;
		if (fall === 1'b1) fall_cnt <= fall_cnt + 1;
	end
	hsp_host_model hsp_host_model_inst (.clock_in(clock_in), .serial_clk_out(sclk),
		.addr_one_out(host_addr_one), .addr_zero_out(addr_zero_pin), .data_out(host_d),
		.data_oe_out(host_oe));
	hsp_pin_ctrl hsp_pin_ctrl_inst (.clock_in(clock_in), .reset_n_in(reset_n),
		.iface_sel_in(iface_sel), .serial_clk_in(sclk), .serial_in_line_in(sdio),
		.serial_in_line_out(sdio_o), .serial_in_line_oe_out(sdio_oe),
		.addr_bit_one_in(addr_one_pin), .serial_out_line_out(addr_one_o),
		.serial_out_line_oe_out(addr_one_oe), .addr_bit_zero_in(addr_zero_pin),
		.tx_bit_in(tx_bit), .tx_en_in(tx_en), .cfg_wr_in(cfg_wr), .cfg_wdata_in(cfg_wdata),
		.status_in(status), .irq_ack_in(irq_ack), .mode_i2c_out(m_i2c), .mode_spi_out(m_spi),
		.frame_active_out(frame), .sclk_rise_out(rise), .sclk_fall_out(fall),
		.rx_bit_out(rx_bit), .i2c_addr_out(i2c_addr), .cfg_out(cfg),
		.status_change_irq_low_out(irq_low), .clk_outputs_en_out(clk_en));
	////////////////////////////////////////////////////////////////////////////////
	// compare one value, count it, report a mismatch
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t ns %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	// reset pulse with the strap at the given level
	task automatic do_reset(input logic strap);
		@(posedge clock_in);
		reset_n <= 1'b0;
		iface_sel <= strap;
		wait_clk(2);
		check({7'h00, clk_en}, 8'h00, "clocks on in reset");
		check(cfg, 8'h00, "config not default");
		check({5'h00, m_i2c, m_spi, irq_low}, 8'h01, "logic not reset");
		@(posedge clock_in);
		reset_n <= 1'b1;
		wait_clk(6);
		check({5'h00, m_i2c, m_spi, clk_en}, {5'h00, strap, ~strap, 1'b1}, "mode");
		$display("test reset strap %0b done", strap);
	endtask
	// 3-wire SPI: deselected clocks ignored, read data on shared pin, strap frozen
	task automatic t_spi3();
		r0 = rise_cnt;
		hsp_host_model_inst.clocks(2);
		wait_clk(5);
		check(8'(rise_cnt - r0), 8'h00, "edges while deselected");
		hsp_host_model_inst.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
		iface_sel <= 1'b1;
		wait_clk(4);
		check({7'h00, frame}, 8'h01, "frame not active");
		tx_en <= 1'b1;
		tx_bit <= 1'b1;
		wait_clk(2);
		check({5'h00, sdio_oe, sdio_o, addr_one_oe}, 8'h06, "3-wire drive high");
		tx_bit <= 1'b0;
		wait_clk(2);
		check({7'h00, sdio}, 8'h00, "3-wire drive low");
		r0 = rise_cnt;
		f0 = fall_cnt;
		hsp_host_model_inst.clocks(3);
		wait_clk(5);
		check(8'(rise_cnt - r0), 8'h03, "rise pulses");
		check(8'(fall_cnt - f0), 8'h03, "fall pulses");
		check({6'h00, m_i2c, m_spi}, 8'h01, "mode changed");
		tx_en <= 1'b0;
		hsp_host_model_inst.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
		$display("test spi 3-wire done");
	endtask
	// 4-wire SPI: data pin is input, read data on address-one pin
	task automatic t_spi4();
		@(posedge clock_in);
		cfg_wr <= 1'b1;
		cfg_wdata <= 8'h01;
		@(posedge clock_in);
		cfg_wr <= 1'b0;
		wait_clk(2);
		check(cfg, 8'h01, "config write");
		hsp_host_model_inst.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
		tx_en <= 1'b1;
		tx_bit <= 1'b1;
		wait_clk(4);
		check({5'h00, addr_one_oe, addr_one_o, sdio_oe}, 8'h06, "4-wire drive");
		check({7'h00, rx_bit}, 8'h01, "data in high");
		hsp_host_model_inst.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
		tx_bit <= 1'b0;
		wait_clk(4);
		check({6'h00, rx_bit, addr_one_pin}, 8'h00, "data in low");
		tx_en <= 1'b0;
		hsp_host_model_inst.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
		$display("test spi 4-wire done");
	endtask
	// status change pulls interrupt low until acknowledged
	task automatic t_irq();
		@(posedge clock_in);
		status <= 8'h05;
		wait_clk(6);
		check({7'h00, irq_low}, 8'h00, "irq not low");
		@(posedge clock_in);
		irq_ack <= 1'b1;
		@(posedge clock_in);
		irq_ack <= 1'b0;
		wait_clk(2);
		check({7'h00, irq_low}, 8'h01, "irq not cleared");
		$display("test irq done");
	endtask
	// I2C: both address pins sampled, clock edges still found
	task automatic t_i2c();
		hsp_host_model_inst.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
		wait_clk(5);
		check({6'h00, i2c_addr}, 8'h02, "address 10");
		hsp_host_model_inst.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
		wait_clk(5);
		check({5'h00, i2c_addr, addr_one_oe}, 8'h02, "address 01");
		r0 = rise_cnt;
		hsp_host_model_inst.clocks(2);
		wait_clk(5);
		check(8'(rise_cnt - r0), 8'h02, "i2c rise pulses");
		$display("test i2c done");
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		wait_clk(2);
		reset_n <= 1'b1;
		do_reset(1'b0);
		t_irq();
		t_spi3();
		t_spi4();
		do_reset(1'b0);
		do_reset(1'b1);
		t_i2c();
		tally_and_finish();
	end
	// watchdog well past the expected run of about 150 cycles
	initial begin
		#100000;
		err_total++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: tb/hsp_host_model.sv */
// host-side model of the serial controller facing the pin block
// assumes the bench calls its tasks from the system clock domain
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model (
	input  wire logic clock_in,
	output logic      serial_clk_out,
	output logic      addr_one_out,
	output logic      addr_zero_out,
	output logic      data_out,
	output logic      data_oe_out
);
	// idle: clock parked low, chip select high, data released
	initial begin
		serial_clk_out = 1'b0;
		addr_one_out   = 1'b0;
		addr_zero_out  = 1'b1;
		data_out       = 1'b0;
		data_oe_out    = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// address / chip select pins and data driver, changed just after an edge
	task automatic set_pins(input logic a1, input logic a0, input logic oe, input logic d);
		@(posedge clock_in);
		addr_one_out  <= a1;
		addr_zero_out <= a0;
		data_oe_out   <= oe;
		data_out      <= d;
	endtask
	// burst of 320 ns host clock periods, phase unrelated to the system clock
	task automatic clocks(input int n);
		#13;
		repeat (n) begin
			#160 serial_clk_out = 1'b1;
			#160 serial_clk_out = 1'b0;
		end
	endtask
endmodule
`default_nettype wire
